// [design/lbc_bank_ctrl.sv]
// bank state tracking, command legality and write masking of a four-bank memory
// Functional notes
// - register read on open-row bank holds it reading, then returns active
// - register write holds device writing for its interval, then idle
// - register read accepted while a bank is row-activating
// - register read accepted while a bank is precharging
// - bank state after register read depends on prior state and timers
// - reset is a special register write starting self-initialisation
// - mask low stores a beat, mask high leaves memory unchanged
// - burst terminate acts only on the bank whose burst runs
`timescale 1ns/1ps
`default_nettype none
`include "lbc_defs.svh"

module lbc_bank_ctrl #(
  parameter int CW = `LBC_CW,
  parameter int T_MRR = `LBC_T_MRR,
  parameter int T_MRW = `LBC_T_MRW,
  parameter int T_RRD = `LBC_T_RRD,
  parameter int T_RCD = `LBC_T_RCD,
  parameter int T_RP = `LBC_T_RP,
  parameter int BL = `LBC_BL,
  parameter int INIT_CYC = `LBC_INIT_CYC
) (
  // core clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // link clock from the controller
  input wire logic i_ck,
  // decoded command and write beat, on the link clock
  input wire lbc_pkg::lbc_cmd_s i_cmd,
  input wire lbc_pkg::lbc_wbeat_s i_wbeat,
  // array write port, link clock
  output lbc_pkg::lbc_wout_s o_wr,
  // bank states, four bits each, and refused-command pulse
  output logic [4*`LBC_NBANK-1:0] o_bank_state,
  output logic o_cmd_err,
  // self-initialisation running, core clock
  output logic o_init_busy
);

  localparam int NB = `LBC_NBANK;
  localparam int TMRR = T_MRR;
  localparam int TMRW = T_MRW;
  localparam int TRCD1 = T_RCD - 1;

  if (CW < 2 || CW > 16) $error("counter width out of range");
  if (T_MRR < 1 || T_MRW < 1 || T_RRD < 1 || T_RCD < 1 || T_RP < 1)
    $error("intervals must be at least one cycle");
  if (T_MRR >= 2**CW || T_MRW >= 2**CW || T_RRD >= 2**CW || T_RCD >= 2**CW
      || T_RP >= 2**CW || BL / 2 >= 2**CW) $error("interval exceeds counter");
  if (BL != 4 && BL != 8 && BL != 16) $error("burst length must be 4, 8 or 16");

  lbc_pkg::lbc_cmd_s cmd;
  logic [NB-1:0] is_idle, is_mr, is_rw, is_wr;
  logic bad;
  logic rst_cmd;
  logic done_tgl, done_s, done_evt;
  logic done_seen_reg, done_seen_next;
  logic init_tgl_reg, init_tgl_next;
  logic [1:0] last_bank_reg, last_bank_next;
  logic [CW-1:0] rrd_reg, rrd_next;
  logic err_reg, err_next;
  lbc_pkg::lbc_wout_s wr_reg, wr_next;

  // burst state entered by a read or write
  function automatic lbc_pkg::lbc_bank_e bk_burst(input lbc_pkg::lbc_op_e op);
    bk_burst = (op == lbc_pkg::OP_RD) ? lbc_pkg::BK_READ : lbc_pkg::BK_WRITE;
  endfunction

  // ======================================================================
  // legality check; refused commands become no-operations
  always_comb
  begin
    bad = 1'b0;
    unique case (i_cmd.op)
      lbc_pkg::OP_MRW, lbc_pkg::OP_REF: bad = ~&is_idle;
      lbc_pkg::OP_BST: bad = ~is_rw[last_bank_reg];
      lbc_pkg::OP_ACT: bad = (rrd_reg != '0);
      default: bad = 1'b0;
    endcase
    if (i_cmd.op != lbc_pkg::OP_NOP && |is_mr)
      bad = 1'b1;
    cmd = i_cmd;
    if (bad)
      cmd.op = lbc_pkg::OP_NOP;
  end

  assign rst_cmd = (cmd.op == lbc_pkg::OP_MRW) && (cmd.ma == `LBC_RESET_MA);
  assign done_evt = (done_s != done_seen_reg);

  // ======================================================================
  // self-initialisation in the core domain, joined by toggles
  lbc_init #(.INIT_CYC(INIT_CYC)) u_init (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_req_tgl(init_tgl_reg),
    .o_done_tgl(done_tgl),
    .o_busy(o_init_busy)
  );

  // done toggle returns through its own synchroniser
  lbc_sync #(.W(1)) u_done_sync (
    .i_clk(i_ck),
    .i_rst_n(i_rst_n),
    .i_async(done_tgl),
    .o_sync(done_s)
  );

  // ======================================================================
  // link-side bookkeeping and write path
  always_comb
  begin
    init_tgl_next = init_tgl_reg ^ rst_cmd;
    done_seen_next = done_s;
    last_bank_next = last_bank_reg;
    if (cmd.op == lbc_pkg::OP_RD || cmd.op == lbc_pkg::OP_WR)
      last_bank_next = cmd.bank;
    rrd_next = (rrd_reg != '0) ? rrd_reg - CW'(1) : '0;
    if (cmd.op == lbc_pkg::OP_ACT)
      rrd_next = CW'(T_RRD - 1);
    err_next = bad;
    wr_next.valid = i_wbeat.valid && is_wr[last_bank_reg]
      && (i_wbeat.dm != `LBC_DM_ALL);
    wr_next.bank = last_bank_reg;
    wr_next.data = i_wbeat.data;
    wr_next.be = ~i_wbeat.dm;
  end

  // link-side registers
  always_ff @(posedge i_ck or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      init_tgl_reg <= 1'b0;
      done_seen_reg <= 1'b0;
      last_bank_reg <= 2'h0;
      rrd_reg <= '0;
      err_reg <= 1'b0;
      wr_reg <= '0;
    end
    else
    begin
      init_tgl_reg <= init_tgl_next;
      done_seen_reg <= done_seen_next;
      last_bank_reg <= last_bank_next;
      rrd_reg <= rrd_next;
      err_reg <= err_next;
      wr_reg <= wr_next;
    end
  end

  assign o_wr = wr_reg;
  assign o_cmd_err = err_reg;

  // ======================================================================
  // one state machine per bank
  for (genvar i = 0; i < NB; i++)
  begin : g_bk
    lbc_pkg::lbc_bank_e st_reg, st_next, ret_reg, ret_next;
    logic [CW-1:0] tmr_reg, tmr_next, mtmr_reg, mtmr_next, bcnt_reg, bcnt_next;
    logic ap_reg, ap_next;
    logic [15:0] dur_reg, dur_next;
    logic hit, bst_hit, mrr;

    assign hit = (cmd.bank == 2'(i)) || (cmd.op == lbc_pkg::OP_PRE && cmd.all);
    assign bst_hit = (cmd.op == lbc_pkg::OP_BST) && (last_bank_reg == 2'(i));
    assign mrr = (cmd.op == lbc_pkg::OP_MRR);

    // next bank state
    always_comb
    begin
      st_next = st_reg;
      ret_next = ret_reg;
      ap_next = ap_reg;
      tmr_next = (tmr_reg != '0) ? tmr_reg - CW'(1) : '0;
      mtmr_next = (mtmr_reg != '0) ? mtmr_reg - CW'(1) : '0;
      bcnt_next = (bcnt_reg != '0) ? bcnt_reg - CW'(1) : '0;
      if (mrr && st_reg inside {lbc_pkg::BK_IDLE, lbc_pkg::BK_ROWACT, lbc_pkg::BK_ACTIVE,
          lbc_pkg::BK_PRECH, lbc_pkg::BK_RESET})
      begin
        st_next = lbc_pkg::BK_MRRD;
        ret_next = st_reg;
        mtmr_next = CW'(T_MRR - 1);
      end
      else
      begin
        unique case (st_reg)
          lbc_pkg::BK_IDLE:
            if (cmd.op == lbc_pkg::OP_MRW)
            begin
              st_next = rst_cmd ? lbc_pkg::BK_RESET : lbc_pkg::BK_MRWR;
              mtmr_next = CW'(T_MRW - 1);
            end
            else if (cmd.op == lbc_pkg::OP_ACT && hit)
            begin
              st_next = lbc_pkg::BK_ROWACT;
              tmr_next = CW'(T_RCD - 1);
            end
            else if (cmd.op == lbc_pkg::OP_PRE && hit)
            begin
              st_next = lbc_pkg::BK_PRECH;
              tmr_next = CW'(T_RP - 1);
            end
          lbc_pkg::BK_ROWACT, lbc_pkg::BK_ACTIVE:
            if (cmd.op == lbc_pkg::OP_PRE && hit)
            begin
              st_next = lbc_pkg::BK_PRECH;
              tmr_next = CW'(T_RP - 1);
            end
            else if (st_reg == lbc_pkg::BK_ROWACT)
            begin
              if (tmr_reg == '0)
                st_next = lbc_pkg::BK_ACTIVE;
            end
            else if ((cmd.op == lbc_pkg::OP_RD || cmd.op == lbc_pkg::OP_WR) && hit)
            begin
              st_next = bk_burst(cmd.op);
              bcnt_next = CW'(BL / 2 - 1);
              ap_next = cmd.ap;
            end
          lbc_pkg::BK_READ, lbc_pkg::BK_WRITE:
            if ((cmd.op == lbc_pkg::OP_RD || cmd.op == lbc_pkg::OP_WR) && hit)
            begin
              st_next = bk_burst(cmd.op);
              bcnt_next = CW'(BL / 2 - 1);
              ap_next = cmd.ap;
            end
            else if ((cmd.op == lbc_pkg::OP_PRE && hit && !ap_reg) || bst_hit
                || bcnt_reg == '0)
            begin
              st_next = (ap_reg || cmd.op == lbc_pkg::OP_PRE) ? lbc_pkg::BK_PRECH
                : lbc_pkg::BK_ACTIVE;
              tmr_next = CW'(T_RP - 1);
            end
          lbc_pkg::BK_PRECH:
            if (tmr_reg == '0)
              st_next = lbc_pkg::BK_IDLE;
          lbc_pkg::BK_MRRD:
            if (mtmr_reg == '0)
            begin
              st_next = ret_reg;
              if (ret_reg == lbc_pkg::BK_ROWACT && tmr_reg == '0)
                st_next = lbc_pkg::BK_ACTIVE;
              if (ret_reg == lbc_pkg::BK_PRECH && tmr_reg == '0)
                st_next = lbc_pkg::BK_IDLE;
            end
          lbc_pkg::BK_MRWR:
            if (mtmr_reg == '0)
              st_next = lbc_pkg::BK_IDLE;
          lbc_pkg::BK_RESET:
            if (done_evt)
              st_next = lbc_pkg::BK_IDLE;
          default:
            st_next = lbc_pkg::BK_IDLE;
        endcase
      end
      dur_next = (st_next != st_reg) ? 16'h1 : ((dur_reg == 16'hffff) ? dur_reg : dur_reg + 16'h1);
    end

    // bank registers
    always_ff @(posedge i_ck or negedge i_rst_n)
    begin
      if (!i_rst_n)
      begin
        st_reg <= lbc_pkg::BK_IDLE;
        ret_reg <= lbc_pkg::BK_IDLE;
        tmr_reg <= '0;
        mtmr_reg <= '0;
        bcnt_reg <= '0;
        ap_reg <= 1'b0;
        dur_reg <= 16'h1;
      end
      else
      begin
        st_reg <= st_next;
        ret_reg <= ret_next;
        tmr_reg <= tmr_next;
        mtmr_reg <= mtmr_next;
        bcnt_reg <= bcnt_next;
        ap_reg <= ap_next;
        dur_reg <= dur_next;
      end
    end

    // status vectors and state output
    assign is_idle[i] = (st_reg == lbc_pkg::BK_IDLE);
    assign is_mr[i] = (st_reg == lbc_pkg::BK_MRRD) || (st_reg == lbc_pkg::BK_MRWR);
    assign is_rw[i] = (st_reg == lbc_pkg::BK_READ) || (st_reg == lbc_pkg::BK_WRITE);
    assign is_wr[i] = (st_reg == lbc_pkg::BK_WRITE);
    assign o_bank_state[4*i +: 4] = st_reg;

    // ====================================================================
    // checks on the bank state machine
    sequence s_act_entry;
      st_reg == lbc_pkg::BK_IDLE && cmd.op == lbc_pkg::OP_ACT && hit;
    endsequence

    property p_mrr_len;
      @(posedge i_ck) disable iff (!i_rst_n)
      (st_reg == lbc_pkg::BK_MRRD && st_next != lbc_pkg::BK_MRRD) |-> dur_reg == 16'(T_MRR);
    endproperty
    a_mrr_len: assert property (p_mrr_len)
      else $error("register read state has wrong length");

    property p_mrr_act;
      @(posedge i_ck) disable iff (!i_rst_n)
      (st_reg == lbc_pkg::BK_ACTIVE && mrr) |=> (st_reg == lbc_pkg::BK_MRRD)
        ##TMRR (st_reg == lbc_pkg::BK_ACTIVE);
    endproperty
    a_mrr_act: assert property (p_mrr_act)
      else $error("active bank did not return after register read");

    property p_mrw;
      @(posedge i_ck) disable iff (!i_rst_n)
      (cmd.op == lbc_pkg::OP_MRW && !rst_cmd) |=> (st_reg == lbc_pkg::BK_MRWR)
        ##TMRW (st_reg == lbc_pkg::BK_IDLE);
    endproperty
    a_mrw: assert property (p_mrw)
      else $error("register write state wrong");

    property p_mrr_rowact;
      @(posedge i_ck) disable iff (!i_rst_n)
      (st_reg == lbc_pkg::BK_ROWACT && i_cmd.op == lbc_pkg::OP_MRR && !(|is_mr))
        |=> st_reg == lbc_pkg::BK_MRRD;
    endproperty
    a_mrr_rowact: assert property (p_mrr_rowact)
      else $error("register read refused while row-activating");

    property p_mrr_prech;
      @(posedge i_ck) disable iff (!i_rst_n)
      (st_reg == lbc_pkg::BK_PRECH && i_cmd.op == lbc_pkg::OP_MRR && !(|is_mr))
        |=> st_reg == lbc_pkg::BK_MRRD;
    endproperty
    a_mrr_prech: assert property (p_mrr_prech)
      else $error("register read refused while precharging");

    property p_resolve;
      @(posedge i_ck) disable iff (!i_rst_n)
      (st_reg == lbc_pkg::BK_MRRD && mtmr_reg == '0 && ret_reg == lbc_pkg::BK_ROWACT)
        |-> if (tmr_reg == '0) ##1 st_reg == lbc_pkg::BK_ACTIVE
            else ##1 st_reg == lbc_pkg::BK_ROWACT;
    endproperty
    a_resolve: assert property (p_resolve)
      else $error("state after register read ignores activate timer");

    property p_rcd;
      @(posedge i_ck) disable iff (!i_rst_n)
      s_act_entry ##1 (cmd.op == lbc_pkg::OP_NOP)[*1] |-> (st_reg == lbc_pkg::BK_ROWACT)
        ##TRCD1 (st_reg == lbc_pkg::BK_ROWACT || is_mr[i]);
    endproperty
    a_rcd: assert property (p_rcd)
      else $error("row activation shorter than its count");

    property p_bst;
      @(posedge i_ck) disable iff (!i_rst_n)
      (cmd.op == lbc_pkg::OP_BST && last_bank_reg != 2'(i) && is_rw[i] && bcnt_reg != '0)
        |=> $stable(st_reg);
    endproperty
    a_bst: assert property (p_bst)
      else $error("burst terminate hit a bank without the running burst");
  end

  // ======================================================================
  // checks on reset request and write masking
  property p_reset;
    @(posedge i_ck) disable iff (!i_rst_n)
    rst_cmd |=> (init_tgl_reg != $past(init_tgl_reg)) && (o_bank_state[3:0] == 4'(lbc_pkg::BK_RESET));
  endproperty
  a_reset: assert property (p_reset)
    else $error("reset write did not start initialisation");

  property p_mask;
    @(posedge i_ck) disable iff (!i_rst_n)
    (i_wbeat.valid && is_wr[last_bank_reg]) |=> (o_wr.valid == ($past(i_wbeat.dm) != 2'h3))
      && (o_wr.be == ~$past(i_wbeat.dm));
  endproperty
  a_mask: assert property (p_mask)
    else $error("write mask not applied to beat");

endmodule // lbc_bank_ctrl

`default_nettype wire

// [design/lbc_defs.svh]
// timing counts, widths and field values of the bank command block
`ifndef LBC_DEFS_SVH
`define LBC_DEFS_SVH

// ========================================================================
// interval counts in link clock cycles; burst length in half link cycles
`define LBC_T_MRR 32'h2
`define LBC_T_MRW 32'h5
`define LBC_T_RRD 32'h2
`define LBC_T_RCD 32'h3
`define LBC_T_RP 32'h3
`define LBC_BL 32'h8

// ========================================================================
// self-initialisation length in core clock cycles
`define LBC_INIT_CYC 32'h1388

// ========================================================================
// widths and field values
`define LBC_CW 32'h8
`define LBC_NBANK 32'h4
`define LBC_RESET_MA 8'h3f
`define LBC_DM_ALL 2'h3

`endif

// [design/lbc_pkg.sv]
// types shared by the bank command block
`default_nettype none

package lbc_pkg;

  // ======================================================================
  // command opcodes as decoded from the command/address bus
  typedef enum logic [3:0] {
    OP_NOP, OP_ACT, OP_RD, OP_WR, OP_PRE, OP_MRR, OP_MRW, OP_BST, OP_REF
  } lbc_op_e;

  // ======================================================================
  // per-bank state
  typedef enum logic [3:0] {
    BK_IDLE, BK_ROWACT, BK_ACTIVE, BK_READ, BK_WRITE, BK_PRECH,
    BK_MRRD, BK_MRWR, BK_RESET
  } lbc_bank_e;

  // ======================================================================
  // one decoded command
  typedef struct packed {
    lbc_op_e op;
    logic [1:0] bank;
    logic all;
    logic ap;
    logic [7:0] ma;
  } lbc_cmd_s;

  // one write data beat with its mask
  typedef struct packed {
    logic valid;
    logic [15:0] data;
    logic [1:0] dm;
  } lbc_wbeat_s;

  // one write into the array
  typedef struct packed {
    logic valid;
    logic [1:0] bank;
    logic [15:0] data;
    logic [1:0] be;
  } lbc_wout_s;

endpackage

`default_nettype wire

// [design/lbc_sync.sv]
// three-stage synchroniser that takes a change once stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module lbc_sync #(
  parameter int W = 1
) (
  // clock and reset of the receiving domain
  input wire logic i_clk,
  input wire logic i_rst_n,
  // level from the other domain and its settled copy
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] out_reg;
  logic [W-1:0] out_next;

  if (W < 1) $error("sync width must be at least one");

  // ======================================================================
  // accept a new value only when the last two stages agree
  always_comb
  begin
    out_next = (s2_reg == s3_reg) ? s3_reg : out_reg;
  end

  // first stage feeds only the second
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      out_reg <= '0;
    end
    else
    begin
      s1_reg <= i_async;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      out_reg <= out_next;
    end
  end

  assign o_sync = out_reg;

endmodule // lbc_sync

`default_nettype wire

// [design/lbc_init.sv]
// core-domain self-initialisation sequencer started by a request toggle
`timescale 1ns/1ps
`default_nettype none
`include "lbc_defs.svh"

module lbc_init #(
  parameter int INIT_CYC = `LBC_INIT_CYC
) (
  // core clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // request toggle from the link domain, done toggle back
  input wire logic i_req_tgl,
  output logic o_done_tgl,
  // sequencer running
  output logic o_busy
);

  logic req_s;
  logic seen_reg, seen_next;
  logic busy_reg, busy_next;
  logic done_reg, done_next;
  logic [15:0] cnt_reg, cnt_next;

  if (INIT_CYC < 1 || INIT_CYC > 65535) $error("init count out of range");

  // ======================================================================
  // bring the request toggle into the core domain
  lbc_sync #(.W(1)) u_req_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_async(i_req_tgl),
    .o_sync(req_s)
  );

  // ======================================================================
  // a new request restarts the count; the end flips the done toggle
  always_comb
  begin
    seen_next = seen_reg;
    busy_next = busy_reg;
    done_next = done_reg;
    cnt_next = cnt_reg;
    if (req_s != seen_reg)
    begin
      seen_next = req_s;
      busy_next = 1'b1;
      cnt_next = 16'(INIT_CYC - 1);
    end
    else if (busy_reg)
    begin
      if (cnt_reg == 16'h0)
      begin
        busy_next = 1'b0;
        done_next = ~done_reg;
      end
      else
      begin
        cnt_next = cnt_reg - 16'h1;
      end
    end
  end

  // sequencer registers
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      seen_reg <= 1'b0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      cnt_reg <= 16'h0;
    end
    else
    begin
      seen_reg <= seen_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
      cnt_reg <= cnt_next;
    end
  end

  assign o_done_tgl = done_reg;
  assign o_busy = busy_reg;

endmodule // lbc_init

`default_nettype wire

// [verification/lbc_ctrl_model.sv]
// controller-side model driving commands and write beats on the link clock
`timescale 1ns/1ps
`default_nettype none

module lbc_ctrl_model (
  // link clock
  input wire logic i_ck,
  // command and write beat toward the device
  output lbc_pkg::lbc_cmd_s o_cmd,
  output lbc_pkg::lbc_wbeat_s o_wbeat
);
  // ======================================================================
  // idle bus at time zero
  initial
  begin
    o_cmd = '0;
    o_wbeat = '0;
  end

  // one command for one edge, then no-operation; fl is {all, ap}
  task automatic send(input lbc_pkg::lbc_op_e op, input logic [1:0] bank,
                      input logic [1:0] fl, input logic [7:0] ma);
    @(posedge i_ck);
    o_cmd <= '{op, bank, fl[1], fl[0], ma};
    @(posedge i_ck);
    o_cmd <= '0;
  endtask

  // one beat with its mask on the same edge; released data is inverted
  task automatic beat(input logic [15:0] data, input logic [1:0] dm);
    @(posedge i_ck);
    o_wbeat <= '{1'b1, data, dm};
    @(posedge i_ck);
    o_wbeat <= '{1'b0, ~data, ~dm};
  endtask
endmodule // lbc_ctrl_model

`default_nettype wire

// [verification/tb_top.sv]
// testbench for the bank command block with a controller model
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  // ======================================================================
  // intervals of this run and bench signals
  localparam int T_MRW = 5;
  localparam int T_RP = 3;
  logic i_clk = 1'b0;
  logic i_ck = 1'b0;
  logic i_rst_n = 1'b0;
  lbc_pkg::lbc_cmd_s cmd;
  lbc_pkg::lbc_wbeat_s wbeat;
  lbc_pkg::lbc_wout_s wr;
  logic [15:0] st;
  logic err;
  logic busy;
  int n_errors = 0;
  int check_count = 0;

  // core clock 10 ns, link clock 64 ns
  always #5 i_clk = ~i_clk;
  always #32 i_ck = ~i_ck;

  // controller model and block under test
  lbc_ctrl_model ctl (.i_ck(i_ck), .o_cmd(cmd), .o_wbeat(wbeat));
  lbc_bank_ctrl #(.T_MRR(2), .T_MRW(T_MRW), .T_RRD(3), .T_RCD(3), .T_RP(T_RP), .BL(16),
    .INIT_CYC(20)) uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ck(i_ck), .i_cmd(cmd),
    .i_wbeat(wbeat), .o_wr(wr), .o_bank_state(st), .o_cmd_err(err), .o_init_busy(busy));

  // ======================================================================
  // compare, state and timing helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [15:0] bs(input int b);
    return {12'h000, st[4*b +: 4]};
  endfunction

  function automatic logic [15:0] e(input lbc_pkg::lbc_bank_e s);
    return {12'h000, s};
  endfunction

  task automatic nxt();
    @(posedge i_ck);
    #1;
  endtask

  task automatic tally_and_finish();
    $display("errors=%0d checks=%0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ======================================================================
  // register read while row-activating, then on an open row
  task automatic s_mrr();
    ctl.send(lbc_pkg::OP_ACT, 2'h0, 2'b00, 8'h00);
    ctl.send(lbc_pkg::OP_MRR, 2'h0, 2'b00, 8'h00);
    #1;
    chk(bs(0), e(lbc_pkg::BK_MRRD));
    chk({15'h0, err}, 16'h0000);
    nxt();
    nxt();
    chk(bs(0), e(lbc_pkg::BK_ACTIVE));
    ctl.send(lbc_pkg::OP_MRR, 2'h0, 2'b00, 8'h00);
    #1;
    chk(bs(0), e(lbc_pkg::BK_MRRD));
    nxt();
    chk(bs(0), e(lbc_pkg::BK_MRRD));
    nxt();
    chk(bs(0), e(lbc_pkg::BK_ACTIVE));
  endtask

  // activates to other banks closer than the spacing are refused
  task automatic s_space();
    ctl.send(lbc_pkg::OP_ACT, 2'h1, 2'b00, 8'h00);
    ctl.send(lbc_pkg::OP_ACT, 2'h2, 2'b00, 8'h00);
    #1;
    chk({15'h0, err}, 16'h0001);
    chk(bs(2), e(lbc_pkg::BK_IDLE));
    ctl.send(lbc_pkg::OP_ACT, 2'h2, 2'b00, 8'h00);
    #1;
    chk({15'h0, err}, 16'h0000);
    chk(bs(2), e(lbc_pkg::BK_ROWACT));
  endtask

  // masked and stored beats, then burst terminate with and without a burst
  task automatic s_write();
    nxt();
    ctl.send(lbc_pkg::OP_ACT, 2'h3, 2'b00, 8'h00);
    repeat (3) nxt();
    ctl.send(lbc_pkg::OP_WR, 2'h3, 2'b00, 8'h00);
    #1;
    chk(bs(3), e(lbc_pkg::BK_WRITE));
    ctl.beat(16'ha5c3, 2'b11);
    #1;
    chk({15'h0, wr.valid}, 16'h0000);
    ctl.beat(16'h3c5a, 2'b10);
    #1;
    chk(wr.data, 16'h3c5a);
    chk({11'h0, wr.valid, wr.bank, wr.be}, 16'h001d);
    ctl.send(lbc_pkg::OP_BST, 2'h0, 2'b00, 8'h00);
    #1;
    chk(bs(3), e(lbc_pkg::BK_ACTIVE));
    ctl.send(lbc_pkg::OP_BST, 2'h3, 2'b00, 8'h00);
    #1;
    chk({15'h0, err}, 16'h0001);
    // read after the ended write, cut short so that a write may follow
    ctl.send(lbc_pkg::OP_RD, 2'h3, 2'b00, 8'h00);
    #1;
    chk(bs(3), e(lbc_pkg::BK_READ));
    ctl.send(lbc_pkg::OP_BST, 2'h3, 2'b00, 8'h00);
    #1;
    chk(bs(3), e(lbc_pkg::BK_ACTIVE));
    // write with auto precharge; refresh is refused while banks are open
    ctl.send(lbc_pkg::OP_WR, 2'h3, 2'b01, 8'h00);
    #1;
    chk(bs(3), e(lbc_pkg::BK_WRITE));
    ctl.send(lbc_pkg::OP_REF, 2'h0, 2'b00, 8'h00);
    #1;
    chk({15'h0, err}, 16'h0001);
    // burst of eight link cycles, two of them spent on the refresh above
    repeat (5) nxt();
    chk(bs(3), e(lbc_pkg::BK_WRITE));
    nxt();
    chk(bs(3), e(lbc_pkg::BK_PRECH));
    repeat (T_RP) nxt();
    chk(bs(3), e(lbc_pkg::BK_IDLE));
  endtask

  // precharge of all banks, then a register write holding every bank
  task automatic s_mrw();
    ctl.send(lbc_pkg::OP_PRE, 2'h0, 2'b10, 8'h00);
    #1;
    chk(st, {4{lbc_pkg::BK_PRECH}});
    // register read lands while every bank still precharges
    ctl.send(lbc_pkg::OP_MRR, 2'h0, 2'b00, 8'h00);
    #1;
    chk(st, {4{lbc_pkg::BK_MRRD}});
    nxt();
    nxt();
    chk(st, {4{lbc_pkg::BK_IDLE}});
    ctl.send(lbc_pkg::OP_MRW, 2'h0, 2'b00, 8'h01);
    #1;
    repeat (T_MRW)
    begin
      chk(st, {4{lbc_pkg::BK_MRWR}});
      nxt();
    end
    chk(st, {4{lbc_pkg::BK_IDLE}});
  endtask

  // reset request through the register write, then self-initialisation
  task automatic s_reset();
    int n;
    ctl.send(lbc_pkg::OP_MRW, 2'h0, 2'b00, 8'h3f);
    #1;
    chk(st, {4{lbc_pkg::BK_RESET}});
    n = 0;
    while (busy !== 1'b1 && n < 20)
    begin
      nxt();
      n++;
    end
    chk({15'h0, busy}, 16'h0001);
    n = 0;
    while (st !== {4{lbc_pkg::BK_IDLE}} && n < 40)
    begin
      nxt();
      n++;
    end
    chk(st, {4{lbc_pkg::BK_IDLE}});
  endtask

  // ======================================================================
  // reset, scenarios, verdict
  initial
  begin
    #163;
    i_rst_n = 1'b1;
    nxt();
    chk(st, 16'h0000);
    s_mrr();
    s_space();
    s_write();
    s_mrw();
    s_reset();
    tally_and_finish();
  end

  // watchdog against a hang
  initial
  begin
    #100000;
    n_errors++;
    tally_and_finish();
  end
endmodule // tb_top

`default_nettype wire
